// *** rtl/masked_byte_reg.sv ***
// One host-writable byte register with a per-bit write mask
`default_nettype none
module masked_byte_reg
    import uart_decode_pkg::*;
#(
    parameter logic [7:0] RESET_VALUE = REG_RESET
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    // Write port
    input  wire logic       we,
    input  wire logic [7:0] wmask,
    input  wire logic [7:0] d,
    // Stored value
    output logic      [7:0] q
);
    logic [7:0] value_ff;
    logic [7:0] nxt_value;

    // Only masked bits take new data
    always_comb
    begin
        nxt_value = value_ff;
        if (ce && we)
        begin
            nxt_value = (value_ff & ~wmask) | (d & wmask);
        end
    end

    // Register stage
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            value_ff <= RESET_VALUE;
        end
        else
        begin
            value_ff <= nxt_value;
        end
    end

    assign q = value_ff;
endmodule
`default_nettype wire

// *** rtl/uart_channel_register_decode.sv ***
// Register selection and write gating for one channel of a quad UART
// Notes on behaviour
// - General registers at addresses 0 and 1 reachable only while line_control bit 7 is zero.
// - Divisor low and high bytes mapped only while line_control bit 7 is one.
// - Enhanced feature and flow characters reachable only when line_control equals BF.
// - Enhanced-only bits of INTERRUPT_ENABLES, FIFO control, modem_control need enhanced enable.
// - Address lines plus qualifying register bits together pick the register.
// - Clock-prescale bit changes only while enhanced functions are enabled.
// - Threshold and trigger registers at 6 and 7 need enhanced enable and MCR6.
// - Queue-ready summary at 7 needs all selects, MCR2 one, loop-back off.
`default_nettype none
module uart_channel_register_decode
    import uart_decode_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    // Host bus, same clock domain
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrStrobe,
    input  wire logic       rdStrobe,
    input  wire logic       allSelect,
    output logic      [7:0] rdData,
    // Channel status to be read
    input  wire logic [7:0] rxHolding,
    input  wire logic [7:0] interruptSource,
    input  wire logic [7:0] lineState,
    input  wire logic [7:0] modemState,
    input  wire logic [7:0] queueReadySummary,
    // Data path strobes
    output logic      [7:0] txHolding,
    output logic            txWrite,
    output logic            rxRead,
    output logic            sourceRead,
    output logic            txQueueReset,
    output logic            rxQueueReset,
    // Register contents
    output logic      [7:0] interruptEnables,
    output logic      [7:0] queueControl,
    output logic      [7:0] lineControl,
    output logic      [7:0] modemControl,
    output logic      [7:0] scratch,
    output logic     [15:0] divisor,
    output logic      [7:0] enhancedFeature,
    output logic      [7:0] resumeChar1,
    output logic      [7:0] resumeChar2,
    output logic      [7:0] pauseChar1,
    output logic      [7:0] pauseChar2,
    output logic      [7:0] flowThreshold,
    output logic      [7:0] triggerLevels
);
    logic [7:0] regQ   [NUM_REGS];
    logic       regWe  [NUM_REGS];
    logic [7:0] regMask[NUM_REGS];

    // Qualifiers taken from the stored registers, allSelect, ce and the bus strobes
    logic divisorAccess;
    logic enhancedSet;
    logic enhancedOn;
    logic thresholdOn;
    logic readyOn;
    logic hostWr;
    logic hostRd;

    assign divisorAccess = regQ[R_LCR][LCR_DIVISOR_ACCESS_BIT_BIT];
    assign enhancedSet   = (regQ[R_LCR] == ENH_SET_KEY);
    assign enhancedOn    = regQ[R_EFR][EFR_ENH_BIT];
    assign thresholdOn   = enhancedOn && regQ[R_MCR][MCR_TCR_EN_BIT];
    assign readyOn       = allSelect && regQ[R_MCR][MCR_RDY_EN_BIT]
                           && !regQ[R_MCR][MCR_LOOP_BIT];
    assign hostWr        = ce && wrStrobe;
    assign hostRd        = ce && rdStrobe;

    // Write decode: address plus mode picks the target
    always_comb
    begin
        for (int i = 0; i < NUM_REGS; i++)
        begin
            regWe[i]   = 1'b0;
            regMask[i] = ALL_BITS;
        end
        regMask[R_IER] = enhancedOn ? ALL_BITS : ~IER_ENH_MASK;
        regMask[R_FCR] = (enhancedOn ? ALL_BITS : ~FCR_ENH_MASK) & ~FCR_PULSE_MASK;
        regMask[R_MCR] = enhancedOn ? ALL_BITS : ~MCR_ENH_MASK;
        unique case (addr)
            ADDR_0: regWe[R_DLL] = hostWr && divisorAccess;
            ADDR_1:
            begin
                regWe[R_DLH] = hostWr && divisorAccess;
                regWe[R_IER] = hostWr && !divisorAccess;
            end
            ADDR_2:
            begin
                regWe[R_EFR] = hostWr && enhancedSet;
                regWe[R_FCR] = hostWr && !enhancedSet;
            end
            ADDR_3: regWe[R_LCR] = hostWr;
            ADDR_4:
            begin
                regWe[R_RESUME_CHAR_1] = hostWr && enhancedSet;
                regWe[R_MCR]  = hostWr && !enhancedSet;
            end
            ADDR_5: regWe[R_RESUME_CHAR_2] = hostWr && enhancedSet;
            ADDR_6:
            begin
                regWe[R_PAUSE_CHAR_1] = hostWr && enhancedSet;
                regWe[R_TCR]   = hostWr && !enhancedSet && thresholdOn;
            end
            ADDR_7:
            begin
                regWe[R_PAUSE_CHAR_2] = hostWr && enhancedSet;
                regWe[R_TLR]   = hostWr && !enhancedSet && thresholdOn;
                regWe[R_SPR]   = hostWr && !enhancedSet && !thresholdOn;
            end
        endcase
    end

    // Storage bank
    for (genvar g = 0; g < NUM_REGS; g++)
    begin : gen_regs
        masked_byte_reg #(
            .RESET_VALUE (REG_RESET)
        ) u_reg (
            .clk    (clk),
            .resetn (resetn),
            .ce     (ce),
            .we     (regWe[g]),
            .wmask  (regMask[g]),
            .d      (wrData),
            .q      (regQ[g])
        );
    end

    // Read decode and data-path strobes
    logic [7:0] rdData_ff, nxt_rdData;
    logic [7:0] txHolding_ff, nxt_txHolding;
    logic       txWrite_ff, nxt_txWrite;
    logic       rxRead_ff, nxt_rxRead;
    logic       sourceRead_ff, nxt_sourceRead;
    logic       txQueueReset_ff, nxt_txQueueReset;
    logic       rxQueueReset_ff, nxt_rxQueueReset;

    always_comb
    begin
        nxt_rdData       = rdData_ff;
        nxt_txHolding    = txHolding_ff;
        nxt_txWrite      = 1'b0;
        nxt_rxRead       = 1'b0;
        nxt_sourceRead   = 1'b0;
        nxt_txQueueReset = 1'b0;
        nxt_rxQueueReset = 1'b0;
        if (!ce)
        begin
            nxt_txWrite      = txWrite_ff;
            nxt_rxRead       = rxRead_ff;
            nxt_sourceRead   = sourceRead_ff;
            nxt_txQueueReset = txQueueReset_ff;
            nxt_rxQueueReset = rxQueueReset_ff;
        end
        // Writes to the write-only side of shared addresses
        if (hostWr && addr == ADDR_0 && !divisorAccess)
        begin
            nxt_txHolding = wrData;
            nxt_txWrite   = 1'b1;
        end
        if (hostWr && addr == ADDR_2 && !enhancedSet)
        begin
            nxt_txQueueReset = wrData[FCR_TXRST_BIT];
            nxt_rxQueueReset = wrData[FCR_RXRST_BIT];
        end
        if (hostRd)
        begin
            unique case (addr)
                ADDR_0:
                begin
                    nxt_rdData = divisorAccess ? regQ[R_DLL] : rxHolding;
                    nxt_rxRead = !divisorAccess;
                end
                ADDR_1: nxt_rdData = divisorAccess ? regQ[R_DLH] : regQ[R_IER];
                ADDR_2:
                begin
                    nxt_rdData     = enhancedSet ? regQ[R_EFR] : interruptSource;
                    nxt_sourceRead = !enhancedSet;
                end
                ADDR_3: nxt_rdData = regQ[R_LCR];
                ADDR_4: nxt_rdData = enhancedSet ? regQ[R_RESUME_CHAR_1] : regQ[R_MCR];
                ADDR_5: nxt_rdData = enhancedSet ? regQ[R_RESUME_CHAR_2] : lineState;
                ADDR_6:
                begin
                    if (enhancedSet)
                        nxt_rdData = regQ[R_PAUSE_CHAR_1];
                    else if (thresholdOn)
                        nxt_rdData = regQ[R_TCR];
                    else
                        nxt_rdData = modemState;
                end
                ADDR_7:
                begin
                    if (enhancedSet)
                        nxt_rdData = regQ[R_PAUSE_CHAR_2];
                    else if (readyOn)
                        nxt_rdData = queueReadySummary;
                    else if (thresholdOn)
                        nxt_rdData = regQ[R_TLR];
                    else
                        nxt_rdData = regQ[R_SPR];
                end
            endcase
        end
    end

    // Register stage for read data and strobes
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdData_ff       <= REG_RESET;
            txHolding_ff    <= REG_RESET;
            txWrite_ff      <= 1'b0;
            rxRead_ff       <= 1'b0;
            sourceRead_ff   <= 1'b0;
            txQueueReset_ff <= 1'b0;
            rxQueueReset_ff <= 1'b0;
        end
        else
        begin
            rdData_ff       <= nxt_rdData;
            txHolding_ff    <= nxt_txHolding;
            txWrite_ff      <= nxt_txWrite;
            rxRead_ff       <= nxt_rxRead;
            sourceRead_ff   <= nxt_sourceRead;
            txQueueReset_ff <= nxt_txQueueReset;
            rxQueueReset_ff <= nxt_rxQueueReset;
        end
    end

    // Outputs from flip-flops
    assign rdData           = rdData_ff;
    assign txHolding        = txHolding_ff;
    assign txWrite          = txWrite_ff;
    assign rxRead           = rxRead_ff;
    assign sourceRead       = sourceRead_ff;
    assign txQueueReset     = txQueueReset_ff;
    assign rxQueueReset     = rxQueueReset_ff;
    assign interruptEnables = regQ[R_IER];
    assign queueControl     = regQ[R_FCR];
    assign lineControl      = regQ[R_LCR];
    assign modemControl     = regQ[R_MCR];
    assign scratch          = regQ[R_SPR];
    assign divisor          = {regQ[R_DLH], regQ[R_DLL]};
    assign enhancedFeature  = regQ[R_EFR];
    assign resumeChar1      = regQ[R_RESUME_CHAR_1];
    assign resumeChar2      = regQ[R_RESUME_CHAR_2];
    assign pauseChar1       = regQ[R_PAUSE_CHAR_1];
    assign pauseChar2       = regQ[R_PAUSE_CHAR_2];
    assign flowThreshold    = regQ[R_TCR];
    assign triggerLevels    = regQ[R_TLR];

    // Checks on decode and gating
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_ier_general: assert property (ce && wrStrobe && addr == ADDR_1 && !lineControl[7]
        |=> interruptEnables[3:0] == $past(wrData[3:0]))
        else $error("INTERRUPT_ENABLES low bits not written in general mode");
    a_dll_mapped: assert property (ce && wrStrobe && addr == ADDR_0 && lineControl[7]
        |=> divisor[7:0] == $past(wrData) && !txWrite)
        else $error("divisor low byte write mishandled");
    a_dll_hidden: assert property (ce && wrStrobe && addr == ADDR_0 && !lineControl[7]
        |=> $stable(divisor))
        else $error("divisor changed while hidden");
    a_efr_keyed: assert property (ce && wrStrobe && addr == ADDR_2
        |=> enhancedFeature == ($past(lineControl) == 8'hBF ? $past(wrData)
                                                           : $past(enhancedFeature)))
        else $error("enhanced feature access not keyed by BF");
    a_ier_masked: assert property (ce && wrStrobe && addr == ADDR_1 && !lineControl[7]
        && !enhancedFeature[4] |=> $stable(interruptEnables[7:4]))
        else $error("enhanced INTERRUPT_ENABLES bits written while disabled");
    a_prescale_lock: assert property (ce && wrStrobe && addr == ADDR_4
        && !enhancedFeature[4] |=> $stable(modemControl[7]))
        else $error("prescale bit changed while enhanced off");
    a_tcr_gate: assert property (ce && wrStrobe && addr == ADDR_6 && lineControl != 8'hBF
        |=> flowThreshold == ($past(enhancedFeature[4] && modemControl[6])
                              ? $past(wrData) : $past(flowThreshold)))
        else $error("threshold register gating wrong");
    a_ready_read: assert property (ce && rdStrobe && addr == ADDR_7 && lineControl != 8'hBF
        && allSelect && modemControl[2] && !modemControl[4]
        |=> rdData == $past(queueReadySummary))
        else $error("ready summary not returned");
    a_thr_steer: assert property (ce && wrStrobe && addr == ADDR_0 && !lineControl[7]
        |=> txWrite && txHolding == $past(wrData) ##1 !txWrite || !ce)
        else $error("transmit holding write not steered");
    a_rhr_steer: assert property (ce && rdStrobe && addr == ADDR_0 && !lineControl[7]
        |=> rxRead && rdData == $past(rxHolding))
        else $error("receive holding read not steered");

    c_enh_write: cover property (ce && wrStrobe && addr == ADDR_2 && lineControl == 8'hBF);
    c_div_write: cover property (ce && wrStrobe && addr == ADDR_1 && lineControl[7]);
    c_tlr_write: cover property (ce && wrStrobe && addr == ADDR_7 && thresholdOn);
    c_rdy_read:  cover property (ce && rdStrobe && addr == ADDR_7 && readyOn);
endmodule
`default_nettype wire

// *** rtl/uart_decode_pkg.sv ***
// Constants for the channel register decode: addresses, fields, masks, indices
`default_nettype none
package uart_decode_pkg;
    // Address-line codes
    localparam logic [2:0] ADDR_0 = 3'h0;
    localparam logic [2:0] ADDR_1 = 3'h1;
    localparam logic [2:0] ADDR_2 = 3'h2;
    localparam logic [2:0] ADDR_3 = 3'h3;
    localparam logic [2:0] ADDR_4 = 3'h4;
    localparam logic [2:0] ADDR_5 = 3'h5;
    localparam logic [2:0] ADDR_6 = 3'h6;
    localparam logic [2:0] ADDR_7 = 3'h7;
    // Qualifying field positions
    localparam int LCR_DIVISOR_ACCESS_BIT_BIT     = 7;
    localparam int EFR_ENH_BIT      = 4;
    localparam int MCR_PRESCALE_BIT = 7;
    localparam int MCR_TCR_EN_BIT   = 6;
    localparam int MCR_LOOP_BIT     = 4;
    localparam int MCR_RDY_EN_BIT   = 2;
    localparam int FCR_TXRST_BIT    = 2;
    localparam int FCR_RXRST_BIT    = 1;
    // Line-control key that opens the enhanced set
    localparam logic [7:0] ENH_SET_KEY = 8'hBF;
    // Bits writable only with enhanced functions on
    localparam logic [7:0] IER_ENH_MASK = 8'hF0;
    localparam logic [7:0] FCR_ENH_MASK = 8'h30;
    localparam logic [7:0] MCR_ENH_MASK = 8'hE0;
    // Self-clearing queue reset bits, never stored
    localparam logic [7:0] FCR_PULSE_MASK = 8'h06;
    localparam logic [7:0] ALL_BITS       = 8'hFF;
    localparam logic [7:0] REG_RESET      = 8'h00;
    // Storage indices
    localparam int R_IER   = 0;
    localparam int R_FCR   = 1;
    localparam int R_LCR   = 2;
    localparam int R_MCR   = 3;
    localparam int R_SPR   = 4;
    localparam int R_DLL   = 5;
    localparam int R_DLH   = 6;
    localparam int R_EFR   = 7;
    localparam int R_RESUME_CHAR_1  = 8;
    localparam int R_RESUME_CHAR_2  = 9;
    localparam int R_PAUSE_CHAR_1 = 10;
    localparam int R_PAUSE_CHAR_2 = 11;
    localparam int R_TCR   = 12;
    localparam int R_TLR   = 13;
    localparam int NUM_REGS = 14;
endpackage
`default_nettype wire

// *** tb/host_model.sv ***
// Host processor bus master model for the channel register bus
`default_nettype none
module host_model
(
    // Clock
    input  wire logic       clk,
    // Register bus
    output var logic  [2:0] addr,
    output var logic  [7:0] wrData,
    output var logic        wrStrobe,
    output var logic        rdStrobe,
    input  wire logic [7:0] rdData
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus at time zero
    initial
    begin
        addr     = 3'h0;
        wrData   = 8'h00;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
    end

    // One write, held to the taking edge, then lines released inverted
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr     <= a;
        wrData   <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
        addr     <= ~a;
        wrData   <= ~d;
        // Let the taking edge's register update settle before callers look
        #1;
    endtask

    // One read, data taken just after the taking edge
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr     <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        addr     <= ~a;
        #1;
        d = rdData;
    endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the channel register decode
`default_nettype none
module tb
    import uart_decode_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // Design and host signals
    logic        clk, resetn, ce, allSelect, wrStrobe, rdStrobe;
    logic        txWrite, rxRead, sourceRead, txQueueReset, rxQueueReset;
    logic  [2:0] addr;
    logic  [7:0] wrData, rdData, txHolding, interruptEnables, queueControl;
    logic  [7:0] lineControl, modemControl, scratch, enhancedFeature;
    logic  [7:0] resumeChar1, resumeChar2, pauseChar1, pauseChar2;
    logic  [7:0] flowThreshold, triggerLevels;
    logic [15:0] divisor;
    logic  [7:0] rxHolding = 8'h6C, interruptSource = 8'hC1, lineState = 8'h60;
    logic  [7:0] modemState = 8'hB0, queueReadySummary = 8'h33;
    int          n_errors = 0, n_compared = 0;

    uart_channel_register_decode uart_channel_register_decode_i (
        .clk, .resetn, .ce, .addr, .wrData, .wrStrobe, .rdStrobe, .allSelect, .rdData,
        .rxHolding, .interruptSource, .lineState, .modemState, .queueReadySummary,
        .txHolding, .txWrite, .rxRead, .sourceRead, .txQueueReset, .rxQueueReset,
        .interruptEnables, .queueControl, .lineControl, .modemControl, .scratch,
        .divisor, .enhancedFeature, .resumeChar1, .resumeChar2, .pauseChar1,
        .pauseChar2, .flowThreshold, .triggerLevels
    );

    host_model host_model_i (
        .clk, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData
    );

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic c8(input logic [7:0] got, input logic [7:0] exp);
        chk({8'h00, got}, {8'h00, exp});
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host_model_i.wr(a, d);
    endtask

    // Read and compare
    task automatic rc(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host_model_i.rd(a, v);
        c8(v, exp);
    endtask

    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Line control, enhanced feature, modem control and divisor clear after reset
    task automatic t_reset();
        c8(lineControl, 8'h00);
        c8(enhancedFeature, 8'h00);
        c8(modemControl, 8'h00);
        chk(divisor, 16'h0000);
    endtask

    // General set: shared addresses steer reads and writes apart
    task automatic t_general();
        wr(3'h3, 8'h03);
        wr(3'h0, 8'hA5);
        #1;
        chk({15'h0000, txWrite}, 16'h0001);
        c8(txHolding, 8'hA5);
        rc(3'h0, 8'h6C);
        chk({15'h0000, rxRead}, 16'h0001);
        rc(3'h2, 8'hC1);
        chk({15'h0000, sourceRead}, 16'h0001);
        wr(3'h2, 8'hF7);
        #1;
        chk({14'h0000, txQueueReset, rxQueueReset}, 16'h0003);
        c8(queueControl, 8'hC1);
        rc(3'h5, 8'h60);
        rc(3'h6, 8'hB0);
        wr(3'h7, 8'h5E);
        rc(3'h7, 8'h5E);
    endtask

    // Divisor bytes only with the access bit set
    task automatic t_divisor();
        wr(3'h3, 8'h80);
        wr(3'h0, 8'h34);
        #1;
        chk({15'h0000, txWrite}, 16'h0000);
        wr(3'h1, 8'h12);
        chk(divisor, 16'h1234);
        rc(3'h0, 8'h34);
        rc(3'h1, 8'h12);
        rc(3'h3, 8'h80);
        wr(3'h3, 8'h03);
        wr(3'h1, 8'h05);
        c8(interruptEnables, 8'h05);
        chk(divisor, 16'h1234);
        rc(3'h0, 8'h6C);
    endtask

    // Enhanced-only bits blocked until enhanced functions are on
    task automatic t_gating();
        wr(3'h1, 8'hFF);
        c8(interruptEnables, 8'h0F);
        wr(3'h4, 8'hFF);
        c8(modemControl, 8'h1F);
        wr(3'h4, 8'h80);
        c8(modemControl, 8'h00);
        wr(3'h3, ENH_SET_KEY);
        wr(3'h2, 8'h10);
        c8(enhancedFeature, 8'h10);
        wr(3'h3, 8'h03);
        wr(3'h1, 8'hFF);
        c8(interruptEnables, 8'hFF);
        wr(3'h2, 8'h30);
        c8(queueControl, 8'h30);
        wr(3'h4, 8'h80);
        c8(modemControl, 8'h80);
    endtask

    // Flow characters only under the exact key value
    task automatic t_enhanced();
        wr(3'h3, ENH_SET_KEY);
        wr(3'h4, 8'h11);
        wr(3'h5, 8'h22);
        wr(3'h6, 8'h33);
        wr(3'h7, 8'h44);
        chk({resumeChar1, resumeChar2}, 16'h1122);
        chk({pauseChar1, pauseChar2}, 16'h3344);
        rc(3'h2, 8'h10);
        rc(3'h6, 8'h33);
        wr(3'h3, 8'hBE);
        wr(3'h4, 8'h02);
        c8(modemControl, 8'h02);
        c8(resumeChar1, 8'h11);
        rc(3'h2, 8'hC1);
        wr(3'h3, 8'h03);
    endtask

    // Threshold, trigger and ready summary at addresses 6 and 7
    task automatic t_flow();
        wr(3'h4, 8'h40);
        wr(3'h6, 8'h5A);
        wr(3'h7, 8'h3C);
        chk({flowThreshold, triggerLevels}, 16'h5A3C);
        c8(scratch, 8'h5E);
        rc(3'h6, 8'h5A);
        rc(3'h7, 8'h3C);
        @(posedge clk) allSelect <= 1'b1;
        wr(3'h4, 8'h44);
        rc(3'h7, 8'h33);
        wr(3'h4, 8'h54);
        rc(3'h7, 8'h3C);
        @(posedge clk) allSelect <= 1'b0;
        wr(3'h4, 8'h44);
        rc(3'h7, 8'h3C);
        @(posedge clk) allSelect <= 1'b1;
        wr(3'h4, 8'h04);
        rc(3'h7, 8'h33);
        wr(3'h4, 8'h00);
        rc(3'h6, 8'hB0);
        rc(3'h7, 8'h5E);
    endtask

    // Main sequence
    initial
    begin
        resetn = 1'b0;
        ce = 1'b1;
        allSelect = 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_general();
        t_divisor();
        t_gating();
        t_enhanced();
        t_flow();
        wrap_up();
    end

    // Watchdog, run needs about 120 cycles
    initial
    begin
        #200000;
        n_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
